// >>> verilog/bes_host.sv
// Host sequencer that pre-programs, bulk erases and verifies a flash array.
`timescale 1ns/100ps
`default_nettype none
`include "bes_regs.svh"
// Summary of operation
// - Second 20h write starts the erase pulse.
// - Erase lasts until next command; end with verify.
// - Program every byte to 00h before erasing.
// - Erase-verify is A0h with the byte address.
// - Margin read returning FFh means byte erased.
// - New verify command before every byte read.
// - Verify ascending from 0000h, stop on failure.
// - On failure re-erase, resume at failing address.
// - End verify mode with any valid command.
// - Count pulses, at most 1000 per cycle.
// - Wait 10 ms after erase before verifying.
// - Wait 6 us after verify write before reading.
// - Write FFh twice to return to read.
// - Read array first; skip erase if all FFh.
// - Restart verification at last failing address.
// - Verify only after a pulse; final compare optional.
// - Write only with gate high, select and strobe low.
module bes_host #(
  parameter int ERASE_CYCLES = `BES_ERASE_CYC, // Erase wait in cycles.
  parameter logic [`BES_ADDR_W-1:0] LAST_ADDR = 15'h7fff // Last byte.
) (
  input wire logic CORE_CLK, // Core clock, 100 MHz.
  input wire logic RSTN, // Asynchronous reset, active low.
  input wire logic START, // One-cycle request to run the algorithm.
  output logic BUSY, // High while the algorithm runs.
  output logic DONE, // Erase finished with every byte at FFh.
  output logic FAIL, // Algorithm gave up.
  output logic ALREADY_ERASED, // Array was blank and erasing was skipped.
  output logic [9:0] PULSE_COUNT, // Erase pulses issued.
  output logic [`BES_ADDR_W-1:0] FAIL_ADDR, // Current or failing address.
  output logic [`BES_ADDR_W-1:0] FL_ADDR, // Flash address pins.
  input wire logic [7:0] FL_DQ_IN, // Flash data pins, input side.
  output logic [7:0] FL_DQ_OUT, // Flash data pins, output side.
  output logic FL_DQ_OE, // High while the host drives the data pins.
  output logic FL_CE_N, // Flash chip select, active low.
  output logic FL_WE_N, // Flash write strobe, active low.
  output logic FL_OE_N, // Flash output gate, active low.
  output logic FL_VPP_EN // Switches the high programming supply on.
);
  bes_pkg::bes_host_st_t s; // Registered state.
  bes_pkg::bes_host_st_t next_s; // Next state.
  logic [7:0] dq_sync; // Data pins after the synchroniser.
  logic tmr_expired; // Delay timer idle.
  logic bus_end; // A pin cycle finishes this clock.
  logic wait_over; // The delay just requested has elapsed.

  // Reset value of the whole state: all strobes idle, supply off.
  localparam bes_pkg::bes_host_st_t HOST_RST = '{
    state: bes_pkg::S_IDLE,
    bph: bes_pkg::BP_IDLE,
    bcnt: 5'h00,
    addr: `BES_ADDR_FIRST,
    tries: 5'h00,
    pulse_counter: 10'h000,
    rdata: 8'h00,
    dq_out: 8'h00,
    dq_oe: 1'b0,
    ce_n: 1'b1,
    we_n: 1'b1,
    oe_n: 1'b1,
    vpp_en: 1'b0,
    done: 1'b0,
    fail: 1'b0,
    skipped: 1'b0,
    tmr_go: 1'b0,
    tmr_load: 20'h00000
  };

  // Read data come in through four flip-flops per bit: three stages and the output.
  bes_sync bes_sync_inst (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .d(FL_DQ_IN),
    .q(dq_sync)
  );

  // One timer serves the supply ramp, pulse and recovery waits.
  bes_timer bes_timer_inst (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .go(s.tmr_go),
    .load(s.tmr_load),
    .expired(tmr_expired)
  );

  // Starts a write cycle: select low with the gate high, data driven.
  function automatic bes_pkg::bes_host_st_t wr_go(
    input bes_pkg::bes_host_st_t x,
    input logic [7:0] cmd
  );
    bes_pkg::bes_host_st_t y;
    y = x;
    y.bph = bes_pkg::BP_SETUP;
    y.ce_n = 1'b0;
    y.oe_n = 1'b1;
    y.dq_oe = 1'b1;
    y.dq_out = cmd;
    return y;
  endfunction : wr_go

  // Starts a read cycle: select and gate low, data pins released.
  function automatic bes_pkg::bes_host_st_t rd_go(
    input bes_pkg::bes_host_st_t x
  );
    bes_pkg::bes_host_st_t y;
    y = x;
    y.bph = bes_pkg::BP_RD;
    y.ce_n = 1'b0;
    y.oe_n = 1'b0;
    y.dq_oe = 1'b0;
    y.bcnt = 5'(`BES_RD_CYC - 1);
    return y;
  endfunction : rd_go

  // Requests a delay from the timer in the next cycle.
  function automatic bes_pkg::bes_host_st_t delay(
    input bes_pkg::bes_host_st_t x,
    input logic [19:0] cyc
  );
    bes_pkg::bes_host_st_t y;
    y = x;
    y.tmr_go = 1'b1;
    y.tmr_load = cyc;
    return y;
  endfunction : delay

  assign bus_end = (s.bph == bes_pkg::BP_END);
  // The timer still shows idle in the cycle its load pulse is out.
  assign wait_over = !s.tmr_go && tmr_expired;

  // Pin cycle engine, then the algorithm sequencer.
  always_comb begin
    next_s = s;
    next_s.tmr_go = 1'b0;
    // Pin cycle engine.
    case (s.bph)
      bes_pkg::BP_IDLE: begin
        next_s.bph = bes_pkg::BP_IDLE;
      end
      bes_pkg::BP_SETUP: begin
        // Select is already low, so the strobe falls later.
        next_s.we_n = 1'b0;
        next_s.bph = bes_pkg::BP_STROBE;
        next_s.bcnt = 5'(`BES_WR_CYC - 1);
      end
      bes_pkg::BP_STROBE: begin
        // The strobe stays low for the write pulse width.
        if (s.bcnt == 5'h00) begin
          next_s.we_n = 1'b1;
          next_s.bph = bes_pkg::BP_HOLD;
        end else begin
          next_s.bcnt = s.bcnt - 5'h01;
        end
      end
      bes_pkg::BP_HOLD: begin
        // Data and address held one cycle past the strobe rise.
        next_s.ce_n = 1'b1;
        next_s.dq_oe = 1'b0;
        next_s.bph = bes_pkg::BP_END;
      end
      bes_pkg::BP_RD: begin
        // Access time plus synchroniser latency, then capture.
        if (s.bcnt == 5'h00) begin
          next_s.rdata = dq_sync;
          next_s.ce_n = 1'b1;
          next_s.oe_n = 1'b1;
          next_s.bph = bes_pkg::BP_END;
        end else begin
          next_s.bcnt = s.bcnt - 5'h01;
        end
      end
      bes_pkg::BP_END: begin
        next_s.bph = bes_pkg::BP_IDLE;
      end
      default: begin
        next_s.bph = bes_pkg::BP_IDLE;
      end
    endcase
    // Algorithm sequencer.
    case (s.state)
      bes_pkg::S_IDLE: begin
        // Raise the supply and clear the result of the last run.
        if (START) begin
          next_s.vpp_en = 1'b1;
          next_s.done = 1'b0;
          next_s.fail = 1'b0;
          next_s.skipped = 1'b0;
          next_s.addr = `BES_ADDR_FIRST;
          next_s.tries = 5'h00;
          next_s.pulse_counter = 10'h000;
          next_s = delay(next_s, 20'(`BES_VPP_CYC));
          next_s.state = bes_pkg::S_RAMP;
        end
      end
      bes_pkg::S_RAMP: begin
        // After the ramp the device is in read mode by default.
        if (wait_over) begin
          next_s.state = bes_pkg::S_SCAN;
        end
      end
      bes_pkg::S_SCAN: begin
        // Blank check of the whole array before any erase.
        if (s.bph == bes_pkg::BP_IDLE) begin
          next_s = rd_go(next_s);
        end else if (bus_end) begin
          if (s.rdata != `BES_DATA_ERASED) begin
            next_s.addr = `BES_ADDR_FIRST;
            next_s.state = bes_pkg::S_PP_SET;
          end else if (s.addr == LAST_ADDR) begin
            next_s.skipped = 1'b1;
            next_s.state = bes_pkg::S_RST1;
          end else begin
            next_s.addr = s.addr + 15'h0001;
          end
        end
      end
      bes_pkg::S_PP_SET: begin
        // Program setup before each pre-program pulse.
        if (s.bph == bes_pkg::BP_IDLE) begin
          next_s = wr_go(next_s, `BES_CMD_PROG);
        end else if (bus_end) begin
          next_s.state = bes_pkg::S_PP_PRG;
        end
      end
      bes_pkg::S_PP_PRG: begin
        // Program the current byte to the charged pattern.
        if (s.bph == bes_pkg::BP_IDLE) begin
          next_s = wr_go(next_s, `BES_DATA_ZERO);
        end else if (bus_end) begin
          next_s = delay(next_s, 20'(`BES_PROG_CYC));
          next_s.state = bes_pkg::S_PP_WAIT;
        end
      end
      bes_pkg::S_PP_WAIT: begin
        // Program pulse duration.
        if (wait_over) begin
          next_s.state = bes_pkg::S_PP_VFY;
        end
      end
      bes_pkg::S_PP_VFY: begin
        // Program verify ends the pulse and sets up the margin read.
        if (s.bph == bes_pkg::BP_IDLE) begin
          next_s = wr_go(next_s, `BES_CMD_PROG_VFY);
        end else if (bus_end) begin
          next_s = delay(next_s, 20'(`BES_RECOV_CYC));
          next_s.state = bes_pkg::S_PP_REC;
        end
      end
      bes_pkg::S_PP_REC: begin
        // Recovery before the program verify read.
        if (wait_over) begin
          next_s.state = bes_pkg::S_PP_READ;
        end
      end
      bes_pkg::S_PP_READ: begin
        // Next byte on a match, retry or give up on a mismatch.
        if (s.bph == bes_pkg::BP_IDLE) begin
          next_s = rd_go(next_s);
        end else if (bus_end) begin
          if (s.rdata == `BES_DATA_ZERO) begin
            next_s.tries = 5'h00;
            if (s.addr == LAST_ADDR) begin
              next_s.addr = `BES_ADDR_FIRST;
              next_s.state = bes_pkg::S_ER_SET;
            end else begin
              next_s.addr = s.addr + 15'h0001;
              next_s.state = bes_pkg::S_PP_SET;
            end
          end else if (s.tries == 5'(`BES_MAX_PROG - 1)) begin
            next_s.fail = 1'b1;
            next_s.state = bes_pkg::S_RST1;
          end else begin
            next_s.tries = s.tries + 5'h01;
            next_s.state = bes_pkg::S_PP_SET;
          end
        end
      end
      bes_pkg::S_ER_SET: begin
        // First erase write only arms the device.
        if (s.bph == bes_pkg::BP_IDLE) begin
          next_s = wr_go(next_s, `BES_CMD_ERASE);
        end else if (bus_end) begin
          next_s.state = bes_pkg::S_ER_GO;
        end
      end
      bes_pkg::S_ER_GO: begin
        // Second erase write; its strobe rise starts the pulse.
        if (s.bph == bes_pkg::BP_IDLE) begin
          next_s = wr_go(next_s, `BES_CMD_ERASE);
        end else if (bus_end) begin
          next_s.pulse_counter = s.pulse_counter + 10'h001;
          next_s = delay(next_s, 20'(ERASE_CYCLES));
          next_s.state = bes_pkg::S_ER_WAIT;
        end
      end
      bes_pkg::S_ER_WAIT: begin
        // The whole array erases at once while this wait runs.
        if (wait_over) begin
          next_s.state = bes_pkg::S_EV_CMD;
        end
      end
      bes_pkg::S_EV_CMD: begin
        // Erase verify with the byte address stops the pulse.
        if (s.bph == bes_pkg::BP_IDLE) begin
          next_s = wr_go(next_s, `BES_CMD_ERASE_VFY);
        end else if (bus_end) begin
          next_s = delay(next_s, 20'(`BES_RECOV_CYC));
          next_s.state = bes_pkg::S_EV_REC;
        end
      end
      bes_pkg::S_EV_REC: begin
        // Margin voltages settle before the read.
        if (wait_over) begin
          next_s.state = bes_pkg::S_EV_READ;
        end
      end
      bes_pkg::S_EV_READ: begin
        // FFh passes the byte; otherwise erase again from here, or give up once the pulse count reaches the limit.
        if (s.bph == bes_pkg::BP_IDLE) begin
          next_s = rd_go(next_s);
        end else if (bus_end) begin
          if (s.rdata == `BES_DATA_ERASED) begin
            if (s.addr == LAST_ADDR) begin
              next_s.state = bes_pkg::S_RST1;
            end else begin
              next_s.addr = s.addr + 15'h0001;
              next_s.state = bes_pkg::S_EV_CMD;
            end
          end else if (s.pulse_counter == 10'(`BES_MAX_PULSES)) begin
            next_s.fail = 1'b1;
            next_s.state = bes_pkg::S_RST1;
          end else begin
            next_s.state = bes_pkg::S_ER_SET;
          end
        end
      end
      bes_pkg::S_RST1: begin
        // First reset write.
        if (s.bph == bes_pkg::BP_IDLE) begin
          next_s = wr_go(next_s, `BES_CMD_RESET);
        end else if (bus_end) begin
          next_s.state = bes_pkg::S_RST2;
        end
      end
      bes_pkg::S_RST2: begin
        // Second reset write returns the device to array read.
        if (s.bph == bes_pkg::BP_IDLE) begin
          next_s = wr_go(next_s, `BES_CMD_RESET);
        end else if (bus_end) begin
          next_s.state = bes_pkg::S_END;
        end
      end
      bes_pkg::S_END: begin
        // Drop the supply and publish the result.
        next_s.vpp_en = 1'b0;
        next_s.done = !s.fail;
        next_s.state = bes_pkg::S_IDLE;
      end
      default: begin
        next_s = HOST_RST;
      end
    endcase
  end

  // State register.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s <= HOST_RST;
    end else begin
      s <= next_s;
    end
  end

  // Pins and status come straight from the state register.
  assign BUSY = (s.state != bes_pkg::S_IDLE);
  assign DONE = s.done;
  assign FAIL = s.fail;
  assign ALREADY_ERASED = s.skipped;
  assign PULSE_COUNT = s.pulse_counter;
  assign FAIL_ADDR = s.addr;
  assign FL_ADDR = s.addr;
  assign FL_DQ_OUT = s.dq_out;
  assign FL_DQ_OE = s.dq_oe;
  assign FL_CE_N = s.ce_n;
  assign FL_WE_N = s.we_n;
  assign FL_OE_N = s.oe_n;
  assign FL_VPP_EN = s.vpp_en;
endmodule : bes_host
`default_nettype wire

// >>> verilog/bes_regs.svh
// Command codes, data patterns and timing counts of the bulk erase host.
`ifndef BES_REGS_SVH
`define BES_REGS_SVH
// Command bytes written to the flash command register.
`define BES_CMD_READ 8'h00
`define BES_CMD_ERASE 8'h20
`define BES_CMD_ERASE_VFY 8'ha0
`define BES_CMD_PROG 8'h40
`define BES_CMD_PROG_VFY 8'hc0
`define BES_CMD_RESET 8'hff
// Data patterns: a charged cell byte and an erased byte.
`define BES_DATA_ZERO 8'h00
`define BES_DATA_ERASED 8'hff
// Array address width and the first address of every scan.
`define BES_ADDR_W 15
`define BES_ADDR_FIRST 15'h0000
// Attempt limits per reprogramming cycle.
`define BES_MAX_PULSES 1000
`define BES_MAX_PROG 25
// Core clock rate in MHz.
`define BES_CLK_MHZ 100
// Times in their own units.
`define BES_T_ERASE_MS 10
`define BES_T_PROG_US 10
`define BES_T_RECOV_US 6
`define BES_T_WR_NS 100
`define BES_T_RD_NS 100
`define BES_T_VPP_NS 100
// Cycle counts derived from the times, least times rounded up.
`define BES_ERASE_CYC (`BES_T_ERASE_MS * `BES_CLK_MHZ * 1000)
`define BES_PROG_CYC (`BES_T_PROG_US * `BES_CLK_MHZ)
`define BES_RECOV_CYC (`BES_T_RECOV_US * `BES_CLK_MHZ)
`define BES_WR_CYC ((`BES_T_WR_NS * `BES_CLK_MHZ + 999) / 1000)
`define BES_RD_CYC ((`BES_T_RD_NS * `BES_CLK_MHZ + 999) / 1000 + 4)
`define BES_VPP_CYC ((`BES_T_VPP_NS * `BES_CLK_MHZ + 999) / 1000)
`endif

// >>> verilog/bes_pkg.sv
// Types shared by the bulk erase host modules.
`default_nettype none
`include "bes_regs.svh"
package bes_pkg;
  // Sequencer states, one-hot.
  typedef enum logic [17:0] {
    S_IDLE = 18'h00001,
    S_RAMP = 18'h00002,
    S_SCAN = 18'h00004,
    S_PP_SET = 18'h00008,
    S_PP_PRG = 18'h00010,
    S_PP_WAIT = 18'h00020,
    S_PP_VFY = 18'h00040,
    S_PP_REC = 18'h00080,
    S_PP_READ = 18'h00100,
    S_ER_SET = 18'h00200,
    S_ER_GO = 18'h00400,
    S_ER_WAIT = 18'h00800,
    S_EV_CMD = 18'h01000,
    S_EV_REC = 18'h02000,
    S_EV_READ = 18'h04000,
    S_RST1 = 18'h08000,
    S_RST2 = 18'h10000,
    S_END = 18'h20000
  } bes_state_t;
  // Pin cycle phases, one-hot.
  typedef enum logic [5:0] {
    BP_IDLE = 6'h01,
    BP_SETUP = 6'h02,
    BP_STROBE = 6'h04,
    BP_HOLD = 6'h08,
    BP_RD = 6'h10,
    BP_END = 6'h20
  } bes_bus_t;
  // Whole state of the host sequencer.
  typedef struct packed {
    bes_state_t state;
    bes_bus_t bph;
    logic [4:0] bcnt;
    logic [`BES_ADDR_W-1:0] addr;
    logic [4:0] tries;
    logic [9:0] pulse_counter;
    logic [7:0] rdata;
    logic [7:0] dq_out;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic vpp_en;
    logic done;
    logic fail;
    logic skipped;
    logic tmr_go;
    logic [19:0] tmr_load;
  } bes_host_st_t;
  // Whole state of the delay timer.
  typedef struct packed {
    logic run;
    logic [19:0] cnt;
  } bes_tmr_st_t;
  // Whole state of the data pin synchroniser.
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] q;
  } bes_sync_st_t;
endpackage : bes_pkg
`default_nettype wire

// >>> verilog/bes_timer.sv
// Down-counting delay timer used for the supply ramp, pulse and recovery waits of the host.
`timescale 1ns/100ps
`default_nettype none
module bes_timer (
  input wire logic clk, // Core clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic go, // One-cycle pulse that loads the count.
  input wire logic [19:0] load, // Count in clock cycles.
  output logic expired // High while no delay is running.
);
  bes_pkg::bes_tmr_st_t s; // Registered state.
  bes_pkg::bes_tmr_st_t next_s; // Next state.

  // A load restarts the count; otherwise count down and stop at zero.
  always_comb begin
    next_s = s;
    if (go) begin
      next_s.run = 1'b1;
      next_s.cnt = load;
    end else if (s.run) begin
      if (s.cnt == 20'h00000) begin
        next_s.run = 1'b0;
      end else begin
        next_s.cnt = s.cnt - 20'h00001;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // The delay is over once the counter has stopped.
  assign expired = !s.run;
endmodule : bes_timer
`default_nettype wire

// >>> verilog/bes_sync.sv
// Three-stage synchroniser for the flash data pins.
`timescale 1ns/100ps
`default_nettype none
module bes_sync (
  input wire logic clk, // Core clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic [7:0] d, // Asynchronous pin levels.
  output logic [7:0] q // Accepted levels.
);
  bes_pkg::bes_sync_st_t s; // Registered state.
  bes_pkg::bes_sync_st_t next_s; // Next state.
  logic [7:0] pick; // Accepted value per bit.

  // A bit changes only once the second and third stages agree.
  generate
    for (genvar i = 0; i < 8; i++) begin : g_bit
      assign pick[i] = (s.s2[i] == s.s3[i]) ? s.s2[i] : s.q[i];
    end
  endgenerate

  // Shift the stages; the first stage feeds only the second.
  always_comb begin
    next_s = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.q = pick;
  end

  // State register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule : bes_sync
`default_nettype wire

// >>> dv/bes_host_checker.sv
// Concurrent checks on the pins and status ports of the bulk erase host.
`timescale 1ns/100ps
`default_nettype none
module bes_host_checker #(
  parameter logic [14:0] LAST_ADDR = 15'h7fff // Last array byte.
) (
  input wire logic CORE_CLK, // Core clock.
  input wire logic RSTN, // Reset, active low.
  input wire logic START, // Run request.
  input wire logic BUSY, // Run in progress.
  input wire logic DONE, // Success flag.
  input wire logic FAIL, // Failure flag.
  input wire logic [9:0] PULSE_COUNT, // Erase pulses issued.
  input wire logic [14:0] FL_ADDR, // Address pins.
  input wire logic FL_DQ_OE, // Data drive enable.
  input wire logic FL_CE_N, // Chip select, active low.
  input wire logic FL_WE_N, // Write strobe, active low.
  input wire logic FL_OE_N, // Output gate, active low.
  input wire logic FL_VPP_EN // Supply switch.
);
  // Every check runs on the core clock and rests during reset.
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  chk_write_gate: assert property (
    !FL_WE_N |-> FL_OE_N && !FL_CE_N)
    else $error("write strobe low without select or with gate low");
  chk_write_supply: assert property (
    !FL_WE_N |-> FL_DQ_OE && FL_VPP_EN)
    else $error("write strobe low without data drive or supply");
  chk_no_contend: assert property (
    !FL_OE_N |-> !FL_DQ_OE && FL_WE_N)
    else $error("output gate low while host drives or writes");
  chk_strobe_width: assert property (
    $fell(FL_WE_N) |-> !FL_WE_N [*8])
    else $error("write strobe pulse too short");
  chk_addr_hold: assert property (
    !FL_CE_N && !$fell(FL_CE_N) |-> $stable(FL_ADDR))
    else $error("address moved inside a bus cycle");
  chk_addr_range: assert property (
    !FL_CE_N |-> FL_ADDR <= LAST_ADDR)
    else $error("address beyond the last byte");
  chk_pulse_step: assert property (
    !$stable(PULSE_COUNT) |->
      PULSE_COUNT == $past(PULSE_COUNT) + 10'h001 || PULSE_COUNT == 10'h000)
    else $error("pulse count jumped");
  chk_pulse_limit: assert property (
    PULSE_COUNT <= 10'h3e8)
    else $error("pulse count above its limit");
  chk_start_supply: assert property (
    START && !BUSY |=> FL_VPP_EN && !DONE && !FAIL)
    else $error("accepted start did not raise supply or clear flags");
endmodule : bes_host_checker
bind bes_host bes_host_checker #(.LAST_ADDR(LAST_ADDR)) bes_host_checker_inst (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .START(START), .BUSY(BUSY),
  .DONE(DONE), .FAIL(FAIL), .PULSE_COUNT(PULSE_COUNT), .FL_ADDR(FL_ADDR),
  .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N),
  .FL_OE_N(FL_OE_N), .FL_VPP_EN(FL_VPP_EN)
);
`default_nettype wire

// >>> dv/bes_flash_model.sv
// Behavioural flash array with its command register, driven by strobes.
`timescale 1ns/100ps
`default_nettype none
module bes_flash_model #(
  parameter int LAST = 3, // Last array byte.
  parameter int ERASE_NS = 500 // Shortest pulse that counts.
) (
  input wire logic ce_n, // Chip select, active low.
  input wire logic we_n, // Write strobe, active low.
  input wire logic oe_n, // Output gate, active low.
  input wire logic vpp, // High supply present.
  input wire logic [14:0] addr, // Address pins.
  input wire logic [7:0] din, // Data written by the host.
  output logic [7:0] dout // Data returned to the host.
);
  logic [7:0] mem [0:LAST]; // Array contents.
  int need [0:LAST]; // Pulses each byte still needs.
  int stuck = -1; // Byte that refuses to program.
  logic [7:0] cmd = 8'h00; // Command register.
  logic [7:0] cmd_off = 8'h00; // Command seen when the supply dropped.
  logic [14:0] la = 15'h0000; // Address latched by the last write.
  logic [14:0] va = 15'h0000; // Address of verify reads.
  logic [7:0] held = 8'h00; // Last byte returned.
  logic [7:0] rd; // Byte the array would return.
  logic erasing = 1'b0; // Erase pulse running.
  logic fresh = 1'b0; // Verify command not yet read.
  realtime t_er = 0; // Start of the erase pulse.
  realtime t_vf = 0; // Time of the verify write.
  int pulses = 0; // Pulses that took effect.
  int errs = 0; // Host misuses seen.
  // Margin byte in verify modes, array byte otherwise.
  assign rd = (cmd == 8'ha0 || cmd == 8'hc0) ? mem[va] : mem[addr];
  // A released bus shows the inverse of the last byte.
  assign dout = (!ce_n && !oe_n) ? rd : ~held;
  always @(posedge oe_n) held = rd;
  // Losing the supply returns the register to read mode.
  always @(negedge vpp) begin
    cmd_off = cmd;
    cmd = 8'h00;
  end
  // The address is taken when the later of select and strobe falls.
  always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) la = addr;
  // A write counts only with a valid strobe state and the supply on.
  always @(posedge we_n) begin
    if (!ce_n && oe_n && vpp) begin
      if (cmd == 8'h20 && !erasing && din == 8'h20) begin
        erasing = 1'b1;
        t_er = $realtime;
        // Only the first pulse of a run needs the charged array.
        for (int i = 0; i <= LAST && pulses == 0; i++)
          if (mem[i] !== 8'h00) errs++;
      end else if (cmd == 8'h40) begin
        va = la;
        if (la != stuck) mem[la] = mem[la] & din;
        cmd = 8'h41;
      end else if (cmd == 8'hff && din == 8'hff) begin
        cmd = 8'h00;
      end else begin
        if (erasing) begin
          erasing = 1'b0;
          if (din !== 8'ha0) errs++;
          // Stop timer caps the pulse, so lateness gains nothing.
          if ($realtime - t_er >= ERASE_NS) begin
            pulses++;
            for (int i = 0; i <= LAST; i++) begin
              if (need[i] == 1) mem[i] = 8'hff;
              if (need[i] > 0) need[i]--;
            end
          end else errs++;
        end else if (din == 8'ha0 && cmd != 8'ha0) errs++;
        if (din == 8'ha0) begin
          va = la;
          fresh = 1'b1;
          t_vf = $realtime;
        end
        cmd = din;
      end
    end
  end
  // Each erase verify read needs its own command and the recovery wait.
  always @(negedge oe_n or negedge ce_n) begin
    if (!ce_n && !oe_n && cmd == 8'ha0) begin
      if (!fresh || $realtime - t_vf < 6000) errs++;
      fresh = 1'b0;
    end
  end
endmodule : bes_flash_model
`default_nettype wire

// >>> dv/bes_host_test.sv
// Self-checking bench that runs the bulk erase host against a flash model.
`timescale 1ns/100ps
`default_nettype none
module bes_host_test;
  localparam int LAST = 3; // Small array keeps runs short.
  localparam int ERASE = 50; // Shortened erase wait in cycles.
  logic core_clk = 1'b0; // Core clock.
  logic rstn = 1'b0; // Reset, active low.
  logic start = 1'b0; // Run request.
  logic busy, done, fail, blank, dq_oe, ce_n, we_n, oe_n, vpp; // Status, pins.
  logic [9:0] pulses; // Pulse count output.
  logic [14:0] fail_addr, fl_addr; // Address outputs.
  logic [7:0] dq_out, m_q, dq_in; // Data lines.
  int fail_count = 0; // Mismatches.
  int comparisons = 0; // Checks made.
  // The data wire carries whoever drives it.
  assign dq_in = dq_oe ? dq_out : m_q;
  always #5 core_clk = ~core_clk;
  bes_host #(.ERASE_CYCLES(ERASE), .LAST_ADDR(15'(LAST))) bes_host_inst (
    .CORE_CLK(core_clk), .RSTN(rstn), .START(start), .BUSY(busy),
    .DONE(done), .FAIL(fail), .ALREADY_ERASED(blank), .PULSE_COUNT(pulses),
    .FAIL_ADDR(fail_addr), .FL_ADDR(fl_addr), .FL_DQ_IN(dq_in),
    .FL_DQ_OUT(dq_out), .FL_DQ_OE(dq_oe), .FL_CE_N(ce_n), .FL_WE_N(we_n),
    .FL_OE_N(oe_n), .FL_VPP_EN(vpp)
  );
  bes_flash_model #(.LAST(LAST), .ERASE_NS(ERASE * 10)) bes_flash_model_inst (
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .vpp(vpp), .addr(fl_addr),
    .din(dq_out), .dout(m_q)
  );
  // Counts a check and reports it at once when it fails.
  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : check
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // Mode 0 blank array, 1 programmed array, 2 byte that cannot program.
  task automatic run_case(input int mode);
    int exp_p;
    exp_p = 0;
    bes_flash_model_inst.stuck = (mode == 2) ? 2 : -1;
    bes_flash_model_inst.errs = 0;
    bes_flash_model_inst.pulses = 0;
    for (int i = 0; i <= LAST; i++) begin
      bes_flash_model_inst.mem[i] = (mode == 0) ? 8'hff : 8'($urandom) | 8'h01;
      bes_flash_model_inst.need[i] = (mode == 0) ? 0 : 1 + $urandom % 3;
      if (mode == 1 && bes_flash_model_inst.need[i] > exp_p) begin
        exp_p = bes_flash_model_inst.need[i];
      end
    end
    @(negedge core_clk) start = 1'b1;
    @(negedge core_clk) start = 1'b0;
    // A second request in mid-run must be ignored.
    for (int k = 0; k < 60000 && busy !== 1'b0; k++) begin
      @(negedge core_clk);
      start = (k == 200);
    end
    check(busy === 1'b0, "run ended");
    check(done === (mode != 2), "done flag");
    check(fail === (mode == 2), "fail flag");
    check(blank === (mode == 0), "blank skip");
    check(pulses === 10'(exp_p), "pulse count");
    check(bes_flash_model_inst.pulses == exp_p, "pulses applied");
    check(bes_flash_model_inst.errs == 0, "flash misuse");
    check(bes_flash_model_inst.cmd_off === 8'h00, "read mode");
    if (mode == 2) check(fail_addr === 15'h0002, "failing byte");
    for (int i = 0; i <= LAST && mode == 1; i++) begin
      check(bes_flash_model_inst.mem[i] === 8'hff, "byte erased");
    end
  endtask : run_case
  // Main sequence: reset, then each kind of run.
  initial begin
    void'($urandom(48478));
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    run_case(0);
    run_case(1);
    run_case(1);
    run_case(2);
    tally_and_finish();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #(100000 * 10);
    fail_count++;
    tally_and_finish();
  end
endmodule : bes_host_test
`default_nettype wire
